//--- include/cbs_pkg.sv
// constants, states and helpers for the bus cycle sequencer
package cbs_pkg;
  // input clocks per processor cycle and the counter that divides them
  localparam int CLK_PER_CYCLE = 4;
  localparam logic [1:0] DIV_LAST = 2'(CLK_PER_CYCLE - 1);
  localparam logic [1:0] DIV_RESET = 2'h0;
  // fixed addresses of the reset entry
  localparam logic [15:0] STACK_TOP = 16'h01FF;
  localparam logic [15:0] VEC_LO = 16'hFFFC;
  localparam logic [15:0] VEC_HI = 16'hFFFD;
  localparam logic [7:0] STACK_HI = 8'h01;
  localparam logic [7:0] SP_RESET = 8'hFF;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [7:0] STATUS_PUSH = 8'h34;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  // opcodes the sequencer tells apart
  localparam logic [7:0] OP_LDX_IMM = 8'hA2;
  localparam logic [7:0] OP_LDA_ABX = 8'hBD;
  localparam logic [7:0] OP_JMP_IND = 8'h6C;
  localparam logic [7:0] OP_BRA = 8'h80;
  localparam logic [4:0] OP_RMW_ABX_LOW = 5'h1E;
  // modify kinds carried in opcode bits 7:5
  localparam logic [2:0] MOD_ASL = 3'h0;
  localparam logic [2:0] MOD_ROL = 3'h1;
  localparam logic [2:0] MOD_LSR = 3'h2;
  localparam logic [2:0] MOD_ROR = 3'h3;
  localparam logic [2:0] MOD_DEC = 3'h6;
  localparam logic [2:0] MOD_INC = 3'h7;

  typedef enum logic [2:0] {
    CL_NOP = 3'b000,
    CL_LDX = 3'b001,
    CL_LDAX = 3'b010,
    CL_JIND = 3'b011,
    CL_RMWX = 3'b100,
    CL_BRA = 3'b101
  } cbs_cls_e;

  typedef enum logic [4:0] {
    ST_RST_HOLD = 5'b00000,
    ST_RST_FETCH = 5'b00001,
    ST_RST_DUMMY = 5'b00010,
    ST_PUSH_H = 5'b00011,
    ST_PUSH_L = 5'b00100,
    ST_PUSH_P = 5'b00101,
    ST_VEC_L = 5'b00110,
    ST_VEC_H = 5'b00111,
    ST_FETCH = 5'b01000,
    ST_NOP2 = 5'b01001,
    ST_OP1 = 5'b01010,
    ST_OP2 = 5'b01011,
    ST_FIX = 5'b01100,
    ST_DATA = 5'b01101,
    ST_BRT = 5'b01110,
    ST_JI_EXTRA = 5'b01111,
    ST_JI_LO = 5'b10000,
    ST_JI_HI = 5'b10001,
    ST_RMW_READ = 5'b10010,
    ST_RMW_REREAD = 5'b10011,
    ST_RMW_WRITE = 5'b10100
  } cbs_state_e;

  // sort an opcode into the cycle pattern it needs
  function automatic cbs_cls_e cbs_class(input logic [7:0] op);
    if (op == OP_LDX_IMM) return CL_LDX;
    if (op == OP_LDA_ABX) return CL_LDAX;
    if (op == OP_JMP_IND) return CL_JIND;
    if (op == OP_BRA) return CL_BRA;
    if (op[4:0] == OP_RMW_ABX_LOW && (op[7] ^ op[6]) == 1'b0) return CL_RMWX;
    return CL_NOP;
  endfunction

  // shift, rotate, step: returns carry out and new value
  function automatic logic [8:0] cbs_modify(input logic [2:0] kind, input logic [7:0] v,
                                            input logic c);
    case (kind)
      MOD_ASL: return {v[7], v[6:0], 1'b0};
      MOD_ROL: return {v[7], v[6:0], c};
      MOD_LSR: return {v[0], 1'b0, v[7:1]};
      MOD_ROR: return {v[0], c, v[7:1]};
      MOD_DEC: return {c, 8'(v - 8'h01)};
      MOD_INC: return {c, 8'(v + 8'h01)};
      default: return {c, v};
    endcase
  endfunction
endpackage

//--- include/cbs_clk_if.sv
// cycle enable and quadrature phases from the divider to the sequencer
`timescale 1ns/1ps
interface cbs_clk_if;
  logic cyc_en;
  logic ph_data;
  logic ph_addr;
  modport src (output cyc_en, output ph_data, output ph_addr);
  modport dst (input cyc_en, input ph_data, input ph_addr);
endinterface

//--- src/cbs_clkdiv.sv
// divide-by-four stage with quadrature phase outputs
`timescale 1ns/1ps
module cbs_clkdiv
  import cbs_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  cbs_clk_if.src ck
);
  logic [1:0] cnt_r;
  logic [1:0] cnt_nxt;
  logic ph_data_r;
  logic ph_addr_r;

  // next count and the phase levels it gives
  assign cnt_nxt = 2'(cnt_r + 2'h1);
  assign ck.cyc_en = (cnt_r == DIV_LAST);
  assign ck.ph_data = ph_data_r;
  assign ck.ph_addr = ph_addr_r;

  // counter and phases, a quarter cycle apart
  always_ff @(posedge clk) begin
    if (!resetn) begin
      cnt_r <= DIV_RESET;
      ph_data_r <= 1'b0;
      ph_addr_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      ph_data_r <= cnt_nxt[1];
      ph_addr_r <= cnt_nxt[1] ^ cnt_nxt[0];
    end
  end
endmodule // cbs_clkdiv

//--- src/cbs_seq.sv
// bus cycle sequencer: divider, reset stacking, fixups and locked rmw
`timescale 1ns/1ps
module cbs_seq
  import cbs_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic bus_en,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe,
  output logic [15:0] addr_out,
  output logic addr_oe,
  output logic rw_out,
  output logic sync_out,
  output logic lock_out,
  output logic ph_data,
  output logic ph_addr
);
  cbs_clk_if ck ();
  cbs_state_e state_r, state_nxt;
  logic [15:0] pc_r, pc_nxt, addr_r, addr_nxt;
  logic [7:0] op_r, op_nxt, lo_r, lo_nxt, hi_r, hi_nxt, x_r, x_nxt;
  logic [7:0] m_r, m_nxt, sp_r, sp_nxt, dout_r, dout_nxt;
  logic rw_r, rw_nxt, sync_r, sync_nxt, lock_r, lock_nxt, c_r, c_nxt;
  cbs_cls_e fetch_cls, op_cls;
  logic [8:0] idx_sum;
  logic [15:0] br_target;
  logic [8:0] mod_res;
  logic br_cross;

  cbs_clkdiv u_div (
    .clk(clk),
    .resetn(resetn),
    .ck(ck)
  );

  // decode and address arithmetic
  assign fetch_cls = cbs_class(data_in);
  assign op_cls = cbs_class(op_r);
  assign idx_sum = {1'b0, lo_r} + {1'b0, x_r};
  assign br_target = 16'(pc_r + {{8{lo_r[7]}}, lo_r});
  assign br_cross = (br_target[15:8] != pc_r[15:8]);
  assign mod_res = cbs_modify(op_r[7:5], m_r, c_r);

  // pins: bus enable isolates address and data
  assign addr_out = addr_r;
  assign addr_oe = bus_en;
  assign data_out = dout_r;
  assign data_oe = bus_en && !rw_r && ck.ph_data;
  assign rw_out = rw_r;
  assign sync_out = sync_r;
  assign lock_out = lock_r;
  assign ph_data = ck.ph_data;
  assign ph_addr = ck.ph_addr;

  // next cycle: state, address and bus status at the end of each cycle
  always_comb begin
    state_nxt = state_r;
    pc_nxt = pc_r;
    addr_nxt = addr_r;
    op_nxt = op_r;
    lo_nxt = lo_r;
    hi_nxt = hi_r;
    x_nxt = x_r;
    m_nxt = m_r;
    sp_nxt = sp_r;
    dout_nxt = dout_r;
    c_nxt = c_r;
    rw_nxt = 1'b1;
    sync_nxt = 1'b0;
    lock_nxt = lock_r;
    case (state_r)
      ST_RST_HOLD: begin
        state_nxt = ST_RST_FETCH;
        addr_nxt = pc_r;
        sync_nxt = 1'b1;
      end
      ST_RST_FETCH: state_nxt = ST_RST_DUMMY;
      ST_RST_DUMMY: begin
        state_nxt = ST_PUSH_H;
        addr_nxt = STACK_TOP;
        rw_nxt = 1'b0;
        dout_nxt = pc_r[15:8];
      end
      ST_PUSH_H, ST_PUSH_L: begin
        state_nxt = (state_r == ST_PUSH_H) ? ST_PUSH_L : ST_PUSH_P;
        sp_nxt = 8'(sp_r - 8'h01);
        addr_nxt = {STACK_HI, 8'(sp_r - 8'h01)};
        rw_nxt = 1'b0;
        dout_nxt = (state_r == ST_PUSH_H) ? pc_r[7:0] : STATUS_PUSH;
      end
      ST_PUSH_P: begin
        state_nxt = ST_VEC_L;
        sp_nxt = 8'(sp_r - 8'h01);
        addr_nxt = VEC_LO;
      end
      ST_VEC_L: begin
        state_nxt = ST_VEC_H;
        lo_nxt = data_in;
        addr_nxt = VEC_HI;
      end
      ST_VEC_H, ST_JI_HI: begin
        state_nxt = ST_FETCH;
        pc_nxt = {data_in, lo_r};
        addr_nxt = {data_in, lo_r};
        sync_nxt = 1'b1;
      end
      ST_FETCH: begin
        op_nxt = data_in;
        pc_nxt = 16'(pc_r + 16'h0001);
        addr_nxt = 16'(pc_r + 16'h0001);
        state_nxt = (fetch_cls == CL_NOP) ? ST_NOP2 : ST_OP1;
        lock_nxt = (fetch_cls == CL_RMWX);
      end
      ST_NOP2: begin
        state_nxt = ST_FETCH;
        sync_nxt = 1'b1;
      end
      ST_OP1: begin
        lo_nxt = data_in;
        pc_nxt = 16'(pc_r + 16'h0001);
        addr_nxt = 16'(pc_r + 16'h0001);
        state_nxt = ST_OP2;
        if (op_cls == CL_LDX) begin
          x_nxt = data_in;
          state_nxt = ST_FETCH;
          sync_nxt = 1'b1;
        end else if (op_cls == CL_BRA) begin
          state_nxt = ST_BRT;
        end
      end
      ST_BRT: begin
        if (br_cross) begin
          state_nxt = ST_FIX;
        end else begin
          state_nxt = ST_FETCH;
          pc_nxt = br_target;
          addr_nxt = br_target;
          sync_nxt = 1'b1;
        end
      end
      ST_OP2: begin
        hi_nxt = data_in;
        pc_nxt = 16'(pc_r + 16'h0001);
        if (op_cls == CL_JIND) begin
          state_nxt = ST_JI_EXTRA;
        end else if (idx_sum[8]) begin
          state_nxt = ST_FIX;
          hi_nxt = 8'(data_in + 8'h01);
        end else begin
          state_nxt = (op_cls == CL_RMWX) ? ST_RMW_READ : ST_DATA;
          addr_nxt = {data_in, idx_sum[7:0]};
        end
      end
      ST_FIX: begin
        if (op_cls == CL_BRA) begin
          state_nxt = ST_FETCH;
          pc_nxt = br_target;
          addr_nxt = br_target;
          sync_nxt = 1'b1;
        end else begin
          state_nxt = (op_cls == CL_RMWX) ? ST_RMW_READ : ST_DATA;
          addr_nxt = {hi_r, idx_sum[7:0]};
        end
      end
      ST_JI_EXTRA: begin
        state_nxt = ST_JI_LO;
        addr_nxt = {hi_r, lo_r};
      end
      ST_JI_LO: begin
        state_nxt = ST_JI_HI;
        lo_nxt = data_in;
        addr_nxt = 16'(addr_r + 16'h0001);
      end
      ST_DATA: begin
        state_nxt = ST_FETCH;
        addr_nxt = pc_r;
        sync_nxt = 1'b1;
      end
      ST_RMW_READ: begin
        m_nxt = data_in;
        state_nxt = ST_RMW_REREAD;
      end
      ST_RMW_REREAD: begin
        state_nxt = ST_RMW_WRITE;
        rw_nxt = 1'b0;
        dout_nxt = mod_res[7:0];
        c_nxt = mod_res[8];
      end
      ST_RMW_WRITE: begin
        state_nxt = ST_FETCH;
        addr_nxt = pc_r;
        sync_nxt = 1'b1;
        lock_nxt = 1'b0;
      end
      default: state_nxt = ST_RST_HOLD;
    endcase
  end

  // registers advance once per bus cycle
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_r <= ST_RST_HOLD;
      pc_r <= PC_RESET;
      addr_r <= PC_RESET;
      {op_r, lo_r, hi_r, x_r, m_r, dout_r} <= {6{BYTE_ZERO}};
      sp_r <= SP_RESET;
      {rw_r, sync_r, lock_r, c_r} <= 4'h8;
    end else if (ck.cyc_en) begin
      state_r <= state_nxt;
      pc_r <= pc_nxt;
      addr_r <= addr_nxt;
      {op_r, lo_r, hi_r, x_r, m_r, dout_r} <= {op_nxt, lo_nxt, hi_nxt, x_nxt, m_nxt, dout_nxt};
      sp_r <= sp_nxt;
      {rw_r, sync_r, lock_r, c_r} <= {rw_nxt, sync_nxt, lock_nxt, c_nxt};
    end
  end

  default clocking dc @(posedge clk); endclocking
  default disable iff (!resetn);

  AST_CYCLE_FOUR: assert property (ck.cyc_en |=> !ck.cyc_en [*3] ##1 ck.cyc_en)
    else $error("bus cycle is not four clocks");
  AST_ADDR_PHASE_LEADS: assert property ($rose(ph_data) |-> ph_addr && $past(ph_addr))
    else $error("address phase does not lead data phase");
  AST_BUS_RELEASE: assert property (!bus_en |-> !addr_oe && !data_oe)
    else $error("bus driven while bus enable low");
  AST_LOCK_ON_WRITE: assert property (state_r == ST_RMW_WRITE |-> lock_out && !rw_out)
    else $error("rmw write without lock");
  AST_STATUS_CODE: assert property (!rw_out |-> !sync_out)
    else $error("write cycle flagged as fetch");
  AST_FIX_REREAD: assert property (ck.cyc_en && state_nxt == ST_FIX |=>
    addr_out == $past(addr_out) && rw_out)
    else $error("fixup cycle left last instruction byte");
  AST_JIND_PLUS_ONE: assert property (ck.cyc_en && state_r == ST_JI_LO |=>
    addr_out == 16'($past(addr_out) + 16'h0001))
    else $error("pointer high byte address wrong");
  AST_RESET_PUSH: assert property (ck.cyc_en && state_r == ST_RST_DUMMY |=>
    addr_out == STACK_TOP && !rw_out ##4 addr_out == {STACK_HI, 8'hFE} && !rw_out)
    else $error("reset stacking out of order");
  AST_RMW_REREAD: assert property (ck.cyc_en && state_r == ST_RMW_READ |=>
    rw_out && addr_out == $past(addr_out) ##4 !rw_out && addr_out == $past(addr_out, 5))
    else $error("rmw reread or write address wrong");
  AST_LOCK_FALL: assert property ($fell(lock_out) |-> $past(state_r) == ST_RMW_WRITE)
    else $error("lock released outside final write");
endmodule // cbs_seq

//--- verif/cbs_mem_model.sv
// memory model on the far side of the sequencer bus
`timescale 1ns/1ps
module cbs_mem_model (
  input wire logic clk,
  input wire logic [15:0] addr,
  input wire logic addr_oe,
  input wire logic rw,
  input wire logic [7:0] wdata,
  input wire logic data_oe,
  input wire logic ph_addr,
  input wire logic ph_data,
  output logic [7:0] rdata
);
  logic [7:0] mem [0:65535];
  logic [7:0] last_r;
  // program image: ldx, lda abs x, asl abs x, jmp ind, dec, inc, rol abs x, bra
  initial begin
    foreach (mem[i]) mem[i] = 8'hEA;
    mem[16'h0200] = 8'hA2;
    mem[16'h0201] = 8'hC0;
    mem[16'h0202] = 8'hBD;
    mem[16'h0203] = 8'h47;
    mem[16'h0204] = 8'h03;
    mem[16'h0205] = 8'h1E;
    mem[16'h0206] = 8'h40;
    mem[16'h0207] = 8'h03;
    mem[16'h0208] = 8'h6C;
    mem[16'h0209] = 8'hFF;
    mem[16'h020A] = 8'h02;
    mem[16'h0250] = 8'hDE;
    mem[16'h0251] = 8'h10;
    mem[16'h0252] = 8'h02;
    mem[16'h0253] = 8'hFE;
    mem[16'h0254] = 8'h11;
    mem[16'h0255] = 8'h02;
    mem[16'h0256] = 8'h3E;
    mem[16'h0257] = 8'h12;
    mem[16'h0258] = 8'h02;
    mem[16'h0259] = 8'h80;
    mem[16'h025A] = 8'hA4;
    mem[16'h02D1] = 8'h7F;
    mem[16'h02D2] = 8'hC3;
    mem[16'hFFFC] = 8'h00;
    mem[16'hFFFD] = 8'h02;
    mem[16'h02FF] = 8'h50;
    mem[16'h0300] = 8'h02;
    mem[16'h0400] = 8'h41;
    mem[16'h02D0] = 8'h00;
    mem[16'h0407] = 8'h99;
    last_r = 8'h00;
  end
  // released bus shows the inverse of the last value, not a stale copy
  assign rdata = (addr_oe && rw) ? mem[addr] : ~last_r;
  always @(posedge clk) last_r <= rdata;
  // store write data at the last clock of a driven write cycle
  // no other master here: the bench gives the bus away only with lock low
  always @(posedge clk) begin
    if (data_oe && !rw && ph_data && !ph_addr) mem[addr] <= wdata;
  end
endmodule // cbs_mem_model

//--- verif/cpu_bus_cycle_sequencer_tb.sv
// self-checking bench for the bus cycle sequencer
`timescale 1ns/1ps
module cpu_bus_cycle_sequencer_tb import cbs_pkg::*; ;
  logic clk, resetn, bus_en, data_oe, addr_oe, rw_out, sync_out, lock_out, ph_data, ph_addr;
  logic [7:0] data_in, data_out;
  logic [15:0] addr_out;
  int n_mismatch = 0;
  int check_count = 0;
  int clk_n = 0;
  int last_t = 0;

  cbs_seq dut (.clk(clk), .resetn(resetn), .bus_en(bus_en), .data_in(data_in),
    .data_out(data_out), .data_oe(data_oe), .addr_out(addr_out), .addr_oe(addr_oe),
    .rw_out(rw_out), .sync_out(sync_out), .lock_out(lock_out), .ph_data(ph_data),
    .ph_addr(ph_addr));
  cbs_mem_model mem (.clk(clk), .addr(addr_out), .addr_oe(addr_oe), .rw(rw_out),
    .wdata(data_out), .data_oe(data_oe), .ph_addr(ph_addr), .ph_data(ph_data),
    .rdata(data_in));

  // clock and a running edge count
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) clk_n++;

  task automatic conclude();
    if (n_mismatch == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  // find the next address phase and judge that bus cycle
  task automatic cyc(input logic [15:0] a, input logic r, input logic s, input logic l,
                     input logic [8:0] d);
    int k;
    k = 0;
    @(negedge clk);
    while (!(ph_addr === 1'b1 && ph_data === 1'b0) && k < 64) begin
      @(negedge clk);
      k++;
    end
    chk("boundary", 16'h0001, 16'(k < 64));
    chk("addr", a, addr_out);
    chk("rw", 16'(r), 16'(rw_out));
    chk("sync", 16'(s), 16'(sync_out));
    chk("lock", 16'(l), 16'(lock_out));
    if (d[8]) chk("wdata", 16'(d[7:0]), 16'(data_out));
    if (last_t != 0) chk("period", 16'(CLK_PER_CYCLE), 16'(clk_n - last_t));
    last_t = clk_n;
    @(negedge clk);
    chk("quad", 16'h0003, 16'({ph_addr, ph_data}));
    chk("data_oe", 16'(d[8]), 16'(data_oe));
  endtask

  task automatic t_reset();
    cyc(16'h0000, 1, 0, 0, 9'h000);
    cyc(16'h0000, 1, 1, 0, 9'h000);
    cyc(16'h0000, 1, 0, 0, 9'h000);
    cyc(STACK_TOP, 0, 0, 0, 9'h100);
    cyc(16'h01FE, 0, 0, 0, 9'h100);
    cyc(16'h01FD, 0, 0, 0, {1'b1, STATUS_PUSH});
    cyc(VEC_LO, 1, 0, 0, 9'h000);
    cyc(VEC_HI, 1, 0, 0, 9'h000);
  endtask

  task automatic t_index();
    cyc(16'h0200, 1, 1, 0, 9'h000);
    cyc(16'h0201, 1, 0, 0, 9'h000);
    cyc(16'h0202, 1, 1, 0, 9'h000);
    cyc(16'h0203, 1, 0, 0, 9'h000);
    cyc(16'h0204, 1, 0, 0, 9'h000);
    cyc(16'h0204, 1, 0, 0, 9'h000);
    cyc(16'h0407, 1, 0, 0, 9'h000);
  endtask

  task automatic t_rmw();
    cyc(16'h0205, 1, 1, 0, 9'h000);
    cyc(16'h0206, 1, 0, 1, 9'h000);
    cyc(16'h0207, 1, 0, 1, 9'h000);
    cyc(16'h0207, 1, 0, 1, 9'h000);
    cyc(16'h0400, 1, 0, 1, 9'h000);
    cyc(16'h0400, 1, 0, 1, 9'h000);
    cyc(16'h0400, 0, 0, 1, 9'h182);
  endtask

  task automatic t_jind();
    cyc(16'h0208, 1, 1, 0, 9'h000);
    cyc(16'h0209, 1, 0, 0, 9'h000);
    cyc(16'h020A, 1, 0, 0, 9'h000);
    cyc(16'h020A, 1, 0, 0, 9'h000);
    cyc(16'h02FF, 1, 0, 0, 9'h000);
    cyc(16'h0300, 1, 0, 0, 9'h000);
    cyc(16'h0250, 1, 1, 0, 9'h000);
  endtask

  task automatic t_dec();
    cyc(16'h0251, 1, 0, 1, 9'h000);
    cyc(16'h0252, 1, 0, 1, 9'h000);
    cyc(16'h02D0, 1, 0, 1, 9'h000);
    cyc(16'h02D0, 1, 0, 1, 9'h000);
    cyc(16'h02D0, 0, 0, 1, 9'h1FF);
    cyc(16'h0253, 1, 1, 0, 9'h000);
  endtask

  // inc and rol abs x: one less cycle without page crossing
  task automatic t_incrol();
    cyc(16'h0254, 1, 0, 1, 9'h000);
    cyc(16'h0255, 1, 0, 1, 9'h000);
    cyc(16'h02D1, 1, 0, 1, 9'h000);
    cyc(16'h02D1, 1, 0, 1, 9'h000);
    cyc(16'h02D1, 0, 0, 1, 9'h180);
    cyc(16'h0256, 1, 1, 0, 9'h000);
    cyc(16'h0257, 1, 0, 1, 9'h000);
    cyc(16'h0258, 1, 0, 1, 9'h000);
    cyc(16'h02D2, 1, 0, 1, 9'h000);
    cyc(16'h02D2, 1, 0, 1, 9'h000);
    cyc(16'h02D2, 0, 0, 1, 9'h186);
    cyc(16'h0259, 1, 1, 0, 9'h000);
  endtask

  task automatic t_bra();
    cyc(16'h025A, 1, 0, 0, 9'h000);
    cyc(16'h025B, 1, 0, 0, 9'h000);
    cyc(16'h025B, 1, 0, 0, 9'h000);
    cyc(16'h01FF, 1, 1, 0, 9'h000);
  endtask

  // mid-run reset with the bus given away: pushes run but nothing is driven
  task automatic t_release();
    int w;
    w = 0;
    @(posedge clk);
    while (lock_out !== 1'b0) @(posedge clk);
    bus_en <= 1'b0;
    resetn <= 1'b0;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    repeat (48) begin
      @(negedge clk);
      chk("addr_oe", 16'h0000, 16'(addr_oe));
      chk("data_oe", 16'h0000, 16'(data_oe));
      if (rw_out === 1'b0) w++;
    end
    chk("writes", 16'd12, 16'(w));
    @(posedge clk);
    bus_en <= 1'b1;
    @(negedge clk);
    chk("addr_oe", 16'h0001, 16'(addr_oe));
  endtask

  // watchdog far beyond the expected few hundred clocks
  initial begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    conclude();
  end

  // main sequence
  initial begin
    resetn = 1'b0;
    bus_en = 1'b1;
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    t_reset();
    t_index();
    t_rmw();
    t_jind();
    t_dec();
    t_incrol();
    t_bra();
    t_release();
    conclude();
  end
endmodule // cpu_bus_cycle_sequencer_tb
